/* File: sim/exec_unit_model.sv */
// execution logic model holding segment bases and offset sources
`timescale 1ns/1ps

module exec_unit_model
(
    input wire logic i_clk,
    input wire logic i_wr,
    input wire logic [3:0] i_sel,
    input wire logic [15:0] i_val,
    output logic [15:0] o_cs,
    output logic [15:0] o_ss,
    output logic [15:0] o_ds,
    output logic [15:0] o_es,
    output logic [15:0] o_ip,
    output logic [15:0] o_sp,
    output logic [15:0] o_ea,
    output logic [15:0] o_si,
    output logic [15:0] o_di
);
    logic [15:0] val_reg [9];

    // values start cleared so the generator never sees unknown offsets
    initial
    begin
        foreach (val_reg[k])
            val_reg[k] = 16'h0000;
    end

    // one value updated per write strobe, just after the edge
    always @(posedge i_clk)
    begin
        if (i_wr)
            val_reg[i_sel] <= i_val;
    end

    // presented as levels, like the register file of the execution logic
    assign o_cs = val_reg[0];
    assign o_ss = val_reg[1];
    assign o_ds = val_reg[2];
    assign o_es = val_reg[3];
    assign o_ip = val_reg[4];
    assign o_sp = val_reg[5];
    assign o_ea = val_reg[6];
    assign o_si = val_reg[7];
    assign o_di = val_reg[8];
endmodule

/* File: sim/segmented_address_generator_tb.sv */
// self-checking testbench for the segmented address generator
`timescale 1ns/1ps

module segmented_address_generator_tb;
    import seg_addr_pkg::*;

    // bases and offsets chosen to hit the 64k and megabyte wraps
    localparam logic [15:0] VALS [9] = '{16'h1234, 16'hffff, 16'h0100, 16'habcd,
        16'hfffe, 16'hffff, 16'h8000, 16'hfffe, 16'h0001};
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_req = 1'b0, i_prefix_valid = 1'b0, i_instr_end = 1'b0;
    logic i_str_step = 1'b0, i_str_word = 1'b0, i_direction_control_flag = 1'b0;
    logic i_src_load = 1'b0, i_dst_load = 1'b0, wr = 1'b0;
    logic i_ce = 1'b1;
    logic [15:0] i_word_data = 16'h5502;
    logic [15:0] i_ptr_seg_data = 16'h3b4c;
    logic [3:0] sel = 4'h0;
    logic [15:0] val = 16'h0000, i_disp = 16'h0000;
    ref_kind_t i_ref_kind = REF_FETCH;
    seg_sel_t i_prefix_seg = SEG_DATA;
    logic [15:0] cs, ss, ds, es, ip, sp, ea, si, di;
    logic o_addr_valid, o_override_pending;
    logic [19:0] o_phys_addr, o_phys_addr_hi;
    logic [15:0] o_offset, o_source_index, o_destination_index;
    seg_sel_t o_seg_used;
    logic [7:0] o_byte0, o_byte1, o_byte2, o_byte3;
    int err_total = 0;
    int checks = 0;
    logic [15:0] bv [4];

    always #12.5 i_clk = ~i_clk;

    exec_unit_model u_eu (.i_clk(i_clk), .i_wr(wr), .i_sel(sel), .i_val(val), .o_cs(cs),
        .o_ss(ss), .o_ds(ds), .o_es(es), .o_ip(ip), .o_sp(sp), .o_ea(ea), .o_si(si), .o_di(di));

    segmented_address_generator u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_code_seg_base(cs), .i_stack_seg_base(ss), .i_data_seg_base(ds),
        .i_extra_seg_base(es), .i_instruction_pointer(ip), .i_stack_pointer(sp),
        .i_effective_address(ea), .i_source_index(si), .i_destination_index(di),
        .i_req(i_req), .i_ref_kind(i_ref_kind), .i_disp(i_disp),
        .i_prefix_valid(i_prefix_valid), .i_prefix_seg(i_prefix_seg),
        .i_instr_end(i_instr_end), .i_str_step(i_str_step), .i_str_word(i_str_word),
        .i_direction_control_flag(i_direction_control_flag), .i_src_load(i_src_load),
        .i_dst_load(i_dst_load), .i_word_data(i_word_data), .i_ptr_seg_data(i_ptr_seg_data),
        .o_addr_valid(o_addr_valid), .o_phys_addr(o_phys_addr),
        .o_phys_addr_hi(o_phys_addr_hi), .o_offset(o_offset), .o_seg_used(o_seg_used),
        .o_byte0(o_byte0), .o_byte1(o_byte1), .o_byte2(o_byte2), .o_byte3(o_byte3),
        .o_override_pending(o_override_pending), .o_source_index(o_source_index),
        .o_destination_index(o_destination_index));

    // expected physical address, carry beyond bit 19 dropped by the width
    function automatic logic [19:0] pa(input logic [15:0] b, input logic [15:0] o);
        return {b, 4'h0} + {4'h0, o};
    endfunction

    // compare and count
    task automatic chk(input string n, input logic [19:0] s, input logic [19:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    // one request cycle, sampled once the answer has landed
    task automatic req(input ref_kind_t k, input logic [15:0] d, input logic pv,
        input seg_sel_t ps);
        @(posedge i_clk);
        i_req <= 1'b1;
        i_ref_kind <= k;
        i_disp <= d;
        i_prefix_valid <= pv;
        i_prefix_seg <= ps;
        @(posedge i_clk);
        i_req <= 1'b0;
        i_prefix_valid <= 1'b0;
        #1;
        chk("valid", o_addr_valid, 1);
    endtask

    // single-cycle strobe: 0 end of instruction, 1 source load, 2 dest load, 3 step
    task automatic pulse(input int c, input logic w, input logic d);
        @(posedge i_clk);
        i_instr_end <= (c == 0);
        i_src_load <= (c == 1);
        i_dst_load <= (c == 2);
        i_str_step <= (c == 3);
        i_str_word <= w;
        i_direction_control_flag <= d;
        @(posedge i_clk);
        {i_instr_end, i_src_load, i_dst_load, i_str_step} <= 4'h0;
        #1;
    endtask

    // default segment and offset of every reference kind
    task automatic t_defaults();
        logic [15:0] b, o;
        seg_sel_t g;
        for (int k = 0; k < 6; k++)
        begin
            case (k)
                0: begin b = VALS[0]; o = VALS[4]; g = SEG_CODE; end
                1: begin b = VALS[1]; o = VALS[5]; g = SEG_STACK; end
                2: begin b = VALS[2]; o = VALS[6]; g = SEG_DATA; end
                3: begin b = VALS[2]; o = VALS[7]; g = SEG_DATA; end
                4: begin b = VALS[3]; o = VALS[8]; g = SEG_EXTRA; end
                default: begin b = VALS[1]; o = VALS[6]; g = SEG_STACK; end
            endcase
            req(ref_kind_t'(k), 16'h0000, 1'b0, SEG_DATA);
            chk("seg", o_seg_used, g);
            chk("addr", o_phys_addr, pa(b, o));
            chk("ofs", o_offset, o);
            chk("addr_hi", o_phys_addr_hi, pa(b, o + 16'h0002));
        end
        req(REF_VAR, 16'h9000, 1'b0, SEG_DATA);
        chk("ofs_wrap", o_phys_addr, pa(VALS[2], 16'h1000));
        chk("b0", o_byte0, 8'h02);
        chk("b1", o_byte1, 8'h55);
        chk("b2", o_byte2, 8'h4c);
        chk("b3", o_byte3, 8'h3b);
    endtask

    // each override segment, ignored kinds, then expiry at instruction end
    task automatic t_override();
        for (int s = 0; s < 4; s++)
        begin
            req(REF_VAR, 16'h0000, 1'b1, seg_sel_t'(s));
            chk("ovr_seg", o_seg_used, s);
            chk("ovr_addr", o_phys_addr, pa(bv[s], VALS[6]));
            chk("pend", o_override_pending, 1);
            req(REF_FETCH, 16'h0000, 1'b0, SEG_DATA);
            chk("fetch_seg", o_seg_used, SEG_CODE);
            req(REF_STACK, 16'h0000, 1'b0, SEG_DATA);
            chk("stack_seg", o_seg_used, SEG_STACK);
            req(REF_STR_DST, 16'h0000, 1'b0, SEG_DATA);
            chk("dst_seg", o_seg_used, SEG_EXTRA);
            req(REF_STR_SRC, 16'h0000, 1'b0, SEG_DATA);
            chk("src_seg", o_seg_used, s);
            req(REF_BASE_PTR, 16'h0000, 1'b0, SEG_DATA);
            chk("bp_seg", o_seg_used, s);
            pulse(0, 1'b0, 1'b0);
            chk("pend_clr", o_override_pending, 0);
            req(REF_VAR, 16'h0000, 1'b0, SEG_DATA);
            chk("dflt_again", o_seg_used, SEG_DATA);
        end
    endtask

    // index stepping by element size in both directions, with wrap
    task automatic t_string();
        pulse(3, 1'b1, 1'b0);
        chk("si_inc_w", o_source_index, 16'h0000);
        chk("di_inc_w", o_destination_index, 16'h0003);
        pulse(3, 1'b0, 1'b1);
        chk("si_dec_b", o_source_index, 16'hffff);
        chk("di_dec_b", o_destination_index, 16'h0002);
    endtask

    // clock enable low freezes requests, stepping and byte lanes
    task automatic t_ce_hold();
        @(posedge i_clk);
        i_ce <= 1'b0;
        i_word_data <= 16'ha1b2;
        i_ptr_seg_data <= 16'hc3d4;
        i_req <= 1'b1;
        i_str_step <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_req <= 1'b0;
        i_str_step <= 1'b0;
        #1;
        chk("ce_valid", o_addr_valid, 0);
        chk("ce_si", o_source_index, 16'hffff);
        chk("ce_b0", o_byte0, 8'h02);
        chk("ce_b2", o_byte2, 8'h4c);
        @(posedge i_clk);
        i_ce <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("new_b0", o_byte0, 8'hb2);
        chk("new_b1", o_byte1, 8'ha1);
        chk("new_b2", o_byte2, 8'hd4);
        chk("new_b3", o_byte3, 8'hc3);
        chk("new_si", o_source_index, 16'hffff);
    endtask

    task automatic end_of_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog well beyond the hundred or so cycles the scenarios need
    initial
    begin
        #(25 * 5000);
        err_total++;
        end_of_test();
    end

    // main sequence
    initial
    begin
        bv = '{VALS[3], VALS[0], VALS[1], VALS[2]};
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1;
        chk("rst_valid", o_addr_valid, 0);
        chk("rst_seg", o_seg_used, SEG_DATA);
        for (int k = 0; k < 9; k++)
        begin
            @(posedge i_clk);
            wr <= 1'b1;
            sel <= k[3:0];
            val <= VALS[k];
        end
        @(posedge i_clk);
        wr <= 1'b0;
        pulse(1, 1'b0, 1'b0);
        pulse(2, 1'b0, 1'b0);
        chk("si_load", o_source_index, VALS[7]);
        t_defaults();
        t_override();
        t_string();
        t_ce_hold();
        end_of_test();
    end
endmodule

/* File: verilog/seg_addr_pkg.sv */
// constants and types for the segmented address generator
package seg_addr_pkg;
    localparam int OFS_W = 16;
    localparam int PHYS_W = 20;
    localparam int SEG_SHIFT = 4;
    localparam int MEM_BYTES = 1048576;
    localparam logic [PHYS_W-1:0] PHYS_ZERO = 20'h00000;
    localparam logic [OFS_W-1:0] OFS_ZERO = 16'h0000;
    localparam logic [OFS_W-1:0] STEP_BYTE = 16'h0001;
    localparam logic [OFS_W-1:0] STEP_WORD = 16'h0002;
    localparam logic [PHYS_W-1:0] PHYS_ONE = 20'h00001;
    localparam logic [PHYS_W-1:0] PHYS_TWO = 20'h00002;
    localparam logic [PHYS_W-1:0] PHYS_THREE = 20'h00003;
    localparam logic [1:0] BYTE_LANE0 = 2'h0;
    localparam logic [1:0] BYTE_LANE1 = 2'h1;
    localparam logic [1:0] BYTE_LANE2 = 2'h2;
    localparam logic [1:0] BYTE_LANE3 = 2'h3;

    // kind of memory reference issued by the execution logic
    typedef enum logic [2:0] {
        REF_FETCH = 3'h0,
        REF_STACK = 3'h1,
        REF_VAR = 3'h2,
        REF_STR_SRC = 3'h3,
        REF_STR_DST = 3'h4,
        REF_BASE_PTR = 3'h5
    } ref_kind_t;

    // segment selection for an override prefix
    typedef enum logic [1:0] {
        SEG_EXTRA = 2'h0,
        SEG_CODE = 2'h1,
        SEG_STACK = 2'h2,
        SEG_DATA = 2'h3
    } seg_sel_t;
endpackage

/* File: verilog/segmented_address_generator.sv */
// segmented physical address generator with byte ordering for words and pointers
`timescale 1ns/1ps

module segmented_address_generator
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // segment bases
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_code_seg_base,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_stack_seg_base,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_data_seg_base,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_extra_seg_base,
    // offset sources
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_instruction_pointer,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_stack_pointer,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_effective_address,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_source_index,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_destination_index,
    // request
    input wire logic i_req,
    input wire seg_addr_pkg::ref_kind_t i_ref_kind,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_disp,
    // override prefix and instruction boundary
    input wire logic i_prefix_valid,
    input wire seg_addr_pkg::seg_sel_t i_prefix_seg,
    input wire logic i_instr_end,
    // string stepping
    input wire logic i_str_step,
    input wire logic i_str_word,
    input wire logic i_direction_control_flag,
    input wire logic i_src_load,
    input wire logic i_dst_load,
    // word and pointer data to store
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_word_data,
    input wire logic [seg_addr_pkg::OFS_W-1:0] i_ptr_seg_data,
    // outputs
    output logic o_addr_valid,
    output logic [seg_addr_pkg::PHYS_W-1:0] o_phys_addr,
    output logic [seg_addr_pkg::PHYS_W-1:0] o_phys_addr_hi,
    output logic [seg_addr_pkg::OFS_W-1:0] o_offset,
    output seg_addr_pkg::seg_sel_t o_seg_used,
    output logic [7:0] o_byte0,
    output logic [7:0] o_byte1,
    output logic [7:0] o_byte2,
    output logic [7:0] o_byte3,
    output logic o_override_pending,
    output logic [seg_addr_pkg::OFS_W-1:0] o_source_index,
    output logic [seg_addr_pkg::OFS_W-1:0] o_destination_index
);
    import seg_addr_pkg::*;

    // physical address from a base and offset, high carry dropped
    function automatic logic [PHYS_W-1:0] phys_of(input logic [OFS_W-1:0] base,
                                                  input logic [OFS_W-1:0] ofs);
        logic [PHYS_W-1:0] shifted;
        shifted = {base, {SEG_SHIFT{1'b0}}};
        phys_of = shifted + {{(PHYS_W-OFS_W){1'b0}}, ofs};
    endfunction

    // base value of a selected segment
    function automatic logic [OFS_W-1:0] base_of(input seg_sel_t sel,
                                                 input logic [OFS_W-1:0] cs,
                                                 input logic [OFS_W-1:0] ss,
                                                 input logic [OFS_W-1:0] ds,
                                                 input logic [OFS_W-1:0] es);
        case (sel)
            SEG_CODE: base_of = cs;
            SEG_STACK: base_of = ss;
            SEG_DATA: base_of = ds;
            default: base_of = es;
        endcase
    endfunction

    logic ovr_valid_reg;
    seg_sel_t ovr_seg_reg;
    logic [OFS_W-1:0] si_reg;
    logic [OFS_W-1:0] di_reg;
    logic [OFS_W-1:0] step;
    seg_sel_t seg_next;
    logic [OFS_W-1:0] ofs_next;
    logic [OFS_W-1:0] ofs_hi;
    logic ovr_now;
    seg_sel_t ovr_sel;

    // a prefix in the same cycle as the request counts at once
    assign ovr_now = i_prefix_valid | ovr_valid_reg;
    assign ovr_sel = i_prefix_valid ? i_prefix_seg : ovr_seg_reg;
    assign step = i_str_word ? STEP_WORD : STEP_BYTE;
    assign ofs_hi = ofs_next + STEP_WORD;

    // default segment, offset source and override per reference kind
    always_comb
    begin
        seg_next = SEG_DATA;
        ofs_next = i_effective_address;
        case (i_ref_kind)
            REF_FETCH:
            begin
                seg_next = SEG_CODE;
                ofs_next = i_instruction_pointer;
            end
            REF_STACK:
            begin
                seg_next = SEG_STACK;
                ofs_next = i_stack_pointer;
            end
            REF_VAR:
            begin
                seg_next = ovr_now ? ovr_sel : SEG_DATA;
                ofs_next = i_effective_address + i_disp;
            end
            REF_STR_SRC:
            begin
                seg_next = ovr_now ? ovr_sel : SEG_DATA;
                ofs_next = si_reg;
            end
            REF_STR_DST:
            begin
                seg_next = SEG_EXTRA;
                ofs_next = di_reg;
            end
            REF_BASE_PTR:
            begin
                seg_next = ovr_now ? ovr_sel : SEG_STACK;
                ofs_next = i_effective_address + i_disp;
            end
            default:
            begin
                seg_next = SEG_DATA;
                ofs_next = i_effective_address;
            end
        endcase
    end

    // override prefix held until the following instruction ends
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ovr_valid_reg <= 1'b0;
            ovr_seg_reg <= SEG_DATA;
        end
        else if (i_ce)
        begin
            if (i_prefix_valid)
            begin
                ovr_valid_reg <= 1'b1;
                ovr_seg_reg <= i_prefix_seg;
            end
            else if (i_instr_end)
            begin
                ovr_valid_reg <= 1'b0;
            end
        end
    end

    // string index registers, loaded or stepped by element size
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            si_reg <= OFS_ZERO;
            di_reg <= OFS_ZERO;
        end
        else if (i_ce)
        begin
            if (i_src_load)
            begin
                si_reg <= i_source_index;
            end
            else if (i_str_step)
            begin
                si_reg <= i_direction_control_flag ? si_reg - step : si_reg + step;
            end
            if (i_dst_load)
            begin
                di_reg <= i_destination_index;
            end
            else if (i_str_step)
            begin
                di_reg <= i_direction_control_flag ? di_reg - step : di_reg + step;
            end
        end
    end

    // registered address outputs, any byte alignment accepted
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_addr_valid <= 1'b0;
            o_phys_addr <= PHYS_ZERO;
            o_phys_addr_hi <= PHYS_ZERO;
            o_offset <= OFS_ZERO;
            o_seg_used <= SEG_DATA;
        end
        else if (i_ce)
        begin
            o_addr_valid <= i_req;
            if (i_req)
            begin
                o_phys_addr <= phys_of(base_of(seg_next, i_code_seg_base, i_stack_seg_base,
                                               i_data_seg_base, i_extra_seg_base), ofs_next);
                o_phys_addr_hi <= phys_of(base_of(seg_next, i_code_seg_base, i_stack_seg_base,
                                                  i_data_seg_base, i_extra_seg_base), ofs_hi);
                o_offset <= ofs_next;
                o_seg_used <= seg_next;
            end
        end
    end

    // byte lanes: word low byte first, pointer offset then segment
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_byte0 <= 8'h00;
            o_byte1 <= 8'h00;
            o_byte2 <= 8'h00;
            o_byte3 <= 8'h00;
        end
        else if (i_ce)
        begin
            o_byte0 <= i_word_data[7:0];
            o_byte1 <= i_word_data[15:8];
            o_byte2 <= i_ptr_seg_data[7:0];
            o_byte3 <= i_ptr_seg_data[15:8];
        end
    end

    // mirrors of internal state
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_override_pending <= 1'b0;
            o_source_index <= OFS_ZERO;
            o_destination_index <= OFS_ZERO;
        end
        else if (i_ce)
        begin
            o_override_pending <= i_prefix_valid | (ovr_valid_reg & ~i_instr_end);
            o_source_index <= i_src_load ? i_source_index
                : (i_str_step ? (i_direction_control_flag ? si_reg - step : si_reg + step)
                : si_reg);
            o_destination_index <= i_dst_load ? i_destination_index
                : (i_str_step ? (i_direction_control_flag ? di_reg - step : di_reg + step)
                : di_reg);
        end
    end

    // fetch always lands in the code segment one cycle later
    property p_fetch_code;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && i_ref_kind == REF_FETCH) |=> (o_seg_used == SEG_CODE);
    endproperty
    a_fetch_code: assert property (p_fetch_code) else $error("fetch not in code segment");

    property p_stack_seg;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && i_ref_kind == REF_STACK) |=> (o_seg_used == SEG_STACK);
    endproperty
    a_stack_seg: assert property (p_stack_seg) else $error("stack not in stack segment");

    property p_dst_extra;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && i_ref_kind == REF_STR_DST) |=> (o_seg_used == SEG_EXTRA);
    endproperty
    a_dst_extra: assert property (p_dst_extra) else $error("string dest not extra");

    property p_var_default;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && i_ref_kind == REF_VAR && !ovr_now) |=> (o_seg_used == SEG_DATA);
    endproperty
    a_var_default: assert property (p_var_default) else $error("variable default wrong");

    property p_bp_default;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && i_ref_kind == REF_BASE_PTR && !ovr_now) |=> (o_seg_used == SEG_STACK);
    endproperty
    a_bp_default: assert property (p_bp_default) else $error("base pointer default wrong");

    property p_override_ends;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_instr_end && !i_prefix_valid) |=> !o_override_pending;
    endproperty
    a_override_ends: assert property (p_override_ends) else $error("override outlived instr");

    property p_addr_form;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && i_ref_kind == REF_FETCH) |=>
        (o_phys_addr == {$past(i_code_seg_base), 4'h0} + {4'h0, $past(i_instruction_pointer)});
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("physical address wrong");

    property p_step_dir;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_str_step && !i_src_load && i_direction_control_flag && !i_str_word) |=>
        (si_reg == $past(si_reg) - STEP_BYTE);
    endproperty
    a_step_dir: assert property (p_step_dir) else $error("index step wrong");

    property p_hi_word;
        @(posedge i_clk) disable iff (!i_nrst)
        o_addr_valid |-> (o_phys_addr_hi - o_phys_addr == PHYS_TWO) || (o_offset > 16'hfffd);
    endproperty
    a_hi_word: assert property (p_hi_word) else $error("pointer high word address wrong");

    // word element stepping upward moves the destination index by two
    property p_dst_step;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_str_step && !i_dst_load && !i_direction_control_flag && i_str_word) |=>
        (di_reg == $past(di_reg) + STEP_WORD);
    endproperty
    a_dst_step: assert property (p_dst_step) else $error("destination step wrong");

    // a held prefix steers the string source until the instruction ends
    property p_src_override;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_req && i_ref_kind == REF_STR_SRC && ovr_valid_reg && !i_prefix_valid) |=>
        (o_seg_used == $past(ovr_seg_reg));
    endproperty
    a_src_override: assert property (p_src_override) else $error("source override lost");

    // low byte of a word goes to the lower lane, high byte to the next
    property p_word_order;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ce && i_nrst) |=> ({o_byte1, o_byte0} == $past(i_word_data));
    endproperty
    a_word_order: assert property (p_word_order) else $error("word byte order wrong");
endmodule
